// >>> ccm_map.svh
// register map, field positions and timing constants for the cache miss rate monitor
// Overview of operation
// - gate controller clock only when gate bit set
// - write-enable bit makes tag/data arrays writable
// - controller updates arrays; no protection when enabled
// - 9-bit length sets cacheable region N*64KB
// - OTP caching limits flash length to 16MB
// - 19-bit hit counter counts while running
// - 18-bit miss counter counts while running
// - miss count reaching threshold sets flag, pulse
// - interval countdown end sets flag, pulse
// - enable bit gates monitor interrupt pulse
// - monitor interrupt is a single pulse
// - stopped: counters hold, interval reloads
// - run bit enables hit and miss counting
// - countdown end clears run bit, interrupts
// - 18-bit interval, zero gives no interrupt
// - 18-bit threshold, zero gives no interrupt
// - flush invalidates tags over fixed cycle count
`ifndef CCM_MAP_SVH
`define CCM_MAP_SVH
`define CCM_ADDR_W        32
`define CCM_OFS_CTRL1     32'h400C_3000
`define CCM_OFS_CTRL2     32'h400C_3020
`define CCM_OFS_HITS      32'h400C_3028
`define CCM_OFS_MISSES    32'h400C_302C
`define CCM_OFS_MCTRL     32'h400C_3030
`define CCM_OFS_INTERVAL  32'h400C_3034
`define CCM_OFS_THRESH    32'h400C_3038
`define CCM_RESET_VAL     32'h0000_0000
`define CCM_BIT_FLUSH     0
`define CCM_BIT_OTPCACHE  11
`define CCM_BIT_CGEN      10
`define CCM_BIT_WEN       9
`define CCM_BIT_THRFLAG   3
`define CCM_BIT_INTFLAG   2
`define CCM_BIT_IRQEN     1
`define CCM_BIT_RUN       0
`define CCM_LEN_OTP_MAX   9'h100
`define CCM_FLUSH_8K      16'h0100
`define CCM_FLUSH_16K     16'h0200
`define CCM_CLK_HZ        32'h02FA_F080
`define CCM_REF_HZ        32'h00F4_2400
`endif

// >>> ccm_pkg.sv
// types for the cache miss rate monitor
`default_nettype none
package ccm_pkg;
  typedef struct packed {
    logic        otpCache;
    logic        gateEn;
    logic        memWen;
    logic [8:0]  cacheLen;
  } ccm_ctrl2_t;
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [31:0] addr;
    logic [31:0] wdata;
  } ccm_bus_t;
  typedef struct packed {
    ccm_ctrl2_t  ctrl2;
    logic [18:0] hits;
    logic [17:0] misses;
    logic        thrFlag;
    logic        intFlag;
    logic        irqEn;
    logic        run;
    logic [17:0] interval;
    logic [17:0] thresh;
    logic [17:0] tick;
    logic [31:0] phase;
    logic [15:0] flushCnt;
    logic        irq;
    logic        cacheOn;
    logic        clkGate;
    logic        arrayWen;
    logic        flushOn;
    logic [8:0]  lenOut;
    logic [31:0] rdata;
    logic [1:0]  evSync0;
    logic [1:0]  evSync1;
  } ccm_state_t;
endpackage
`default_nettype wire

// >>> ccm_monitor.sv
// cache controller control register and miss rate monitor
`default_nettype none
`include "ccm_map.svh"
module ccm_monitor
  import ccm_pkg::*;
#(
  parameter bit LARGE_CACHE = 1'b1
) (
  input  wire logic        clock,
  input  wire logic        rst,
  input  wire logic [31:0] busAddr,
  input  wire logic [31:0] busWdata,
  input  wire logic        busWr,
  input  wire logic        busRd,
  output logic      [31:0] busRdata,
  input  wire logic        cacheHit,
  input  wire logic        cacheMiss,
  input  wire logic        cacheBusy,
  output logic             monitorIrq,
  output logic             cacheEnable,
  output logic             clockGateEn,
  output logic             arrayWriteEn,
  output logic             flushBusy,
  output logic      [8:0]  cacheableFlashLength
);
  ccm_state_t s_r, s_nxt;
  logic hitEv, missEv, wr;
  logic thrSet, intSet, runClr;
  logic refTick;
  logic [31:0] phaseSum;

  // limit length when OTP also cached; keeps region inside 16 MB
  function automatic logic [8:0] clipLen(input logic [8:0] len, input logic otp);
    if (otp && len > `CCM_LEN_OTP_MAX) clipLen = `CCM_LEN_OTP_MAX;
    else clipLen = len;
  endfunction

  // fractional accumulator gives 16 MHz tick from 50 MHz without a second clock
  assign phaseSum = s_r.phase + 32'(`CCM_REF_HZ);
  assign refTick = phaseSum >= 32'(`CCM_CLK_HZ);
  // hit/miss strobes come from the cache controller on another timing, so synchronise
  assign hitEv  = s_r.evSync1[0];
  assign missEv = s_r.evSync1[1];
  assign wr = busWr;

  // next-state logic
  always_comb begin
    s_nxt = s_r;
    s_nxt.irq = 1'b0;
    thrSet = 1'b0;
    intSet = 1'b0;
    runClr = 1'b0;
    s_nxt.evSync0 = {cacheMiss, cacheHit};
    s_nxt.evSync1 = s_r.evSync0;
    s_nxt.phase = refTick ? phaseSum - 32'(`CCM_CLK_HZ) : phaseSum;
    if (s_r.flushCnt != 16'h0000) s_nxt.flushCnt = s_r.flushCnt - 16'h0001;
    // counting while running
    if (s_r.run) begin
      if (hitEv) s_nxt.hits = s_r.hits + 19'h0_0001;
      if (missEv) begin
        s_nxt.misses = s_r.misses + 18'h0_0001;
        if (s_r.thresh != 18'h0_0000 && s_nxt.misses == s_r.thresh) begin
          s_nxt.thrFlag = 1'b1;
          thrSet = 1'b1;
          s_nxt.irq = s_r.irqEn;
        end
      end
      if (s_r.interval != 18'h0_0000 && refTick) begin
        if (s_r.tick == 18'h0_0001 || s_r.tick == 18'h0_0000) begin
          s_nxt.tick = s_r.interval;
          s_nxt.run = 1'b0;
          runClr = 1'b1;
          s_nxt.intFlag = 1'b1;
          intSet = 1'b1;
          s_nxt.irq = s_r.irqEn;
        end else begin
          s_nxt.tick = s_r.tick - 18'h0_0001;
        end
      end
    end else begin
      s_nxt.tick = s_r.interval;
    end
    // software writes replace contents; a hardware set in the same cycle wins
    if (wr) begin
      if (busAddr == `CCM_OFS_CTRL1) begin
        if (busWdata[`CCM_BIT_FLUSH])
          s_nxt.flushCnt = LARGE_CACHE ? `CCM_FLUSH_16K : `CCM_FLUSH_8K;
      end else if (busAddr == `CCM_OFS_CTRL2) begin
        s_nxt.ctrl2 = busWdata[11:0];
      end else if (busAddr == `CCM_OFS_HITS) begin
        s_nxt.hits = busWdata[18:0];
      end else if (busAddr == `CCM_OFS_MISSES) begin
        s_nxt.misses = busWdata[17:0];
      end else if (busAddr == `CCM_OFS_MCTRL) begin
        s_nxt.thrFlag = busWdata[`CCM_BIT_THRFLAG] | thrSet;
        s_nxt.intFlag = busWdata[`CCM_BIT_INTFLAG] | intSet;
        s_nxt.irqEn = busWdata[`CCM_BIT_IRQEN];
        s_nxt.run = busWdata[`CCM_BIT_RUN] & ~runClr;
      end else if (busAddr == `CCM_OFS_INTERVAL) begin
        s_nxt.interval = busWdata[17:0];
      end else if (busAddr == `CCM_OFS_THRESH) begin
        s_nxt.thresh = busWdata[17:0];
      end
    end
    // derived controls
    s_nxt.cacheOn = s_nxt.ctrl2.cacheLen != 9'h000;
    s_nxt.clkGate = s_nxt.ctrl2.gateEn & ~cacheBusy & (s_nxt.flushCnt == 16'h0000);
    s_nxt.arrayWen = s_nxt.ctrl2.memWen;
    s_nxt.flushOn = s_nxt.flushCnt != 16'h0000;
    s_nxt.lenOut = clipLen(s_nxt.ctrl2.cacheLen, s_nxt.ctrl2.otpCache);
    // read data, valid only in the cycle after the strobe
    s_nxt.rdata = `CCM_RESET_VAL;
    if (busRd) begin
      if (busAddr == `CCM_OFS_CTRL1) begin
        s_nxt.rdata = `CCM_RESET_VAL;
      end else if (busAddr == `CCM_OFS_CTRL2) begin
        s_nxt.rdata = {20'h0_0000, s_r.ctrl2};
      end else if (busAddr == `CCM_OFS_HITS) begin
        s_nxt.rdata = {13'h0000, s_r.hits};
      end else if (busAddr == `CCM_OFS_MISSES) begin
        s_nxt.rdata = {14'h0000, s_r.misses};
      end else if (busAddr == `CCM_OFS_MCTRL) begin
        s_nxt.rdata = {28'h000_0000, s_r.thrFlag, s_r.intFlag, s_r.irqEn, s_r.run};
      end else if (busAddr == `CCM_OFS_INTERVAL) begin
        s_nxt.rdata = {14'h0000, s_r.interval};
      end else if (busAddr == `CCM_OFS_THRESH) begin
        s_nxt.rdata = {14'h0000, s_r.thresh};
      end
    end
  end

  // state register
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign busRdata = s_r.rdata;
  assign monitorIrq = s_r.irq;
  assign cacheEnable = s_r.cacheOn;
  assign clockGateEn = s_r.clkGate;
  assign arrayWriteEn = s_r.arrayWen;
  assign flushBusy = s_r.flushOn;
  assign cacheableFlashLength = s_r.lenOut;

  // checks on the interrupt pulse
  // interrupt lasts exactly one cycle
  irq_pulse_a: assert property (@(posedge clock) disable iff (rst)
    monitorIrq
    |=> !monitorIrq)
    else $error("irq longer than one cycle");

  // a pulse needs the enable of the cycle before
  irq_mask_a: assert property (@(posedge clock) disable iff (rst)
    monitorIrq
    |-> $past(s_r.irqEn))
    else $error("irq while disabled");

  // masked monitor stays quiet
  irq_quiet_a: assert property (@(posedge clock) disable iff (rst)
    !s_r.irqEn
    |=> !monitorIrq)
    else $error("irq despite mask");

  // every pulse leaves a sticky cause behind
  irq_cause_a: assert property (@(posedge clock) disable iff (rst)
    monitorIrq
    |-> (s_r.thrFlag || s_r.intFlag))
    else $error("irq without a status flag");

  // checks on the miss threshold
  // reaching a nonzero threshold sets the flag
  thr_set_a: assert property (@(posedge clock) disable iff (rst)
    (s_r.run && missEv && s_r.thresh != 18'h0_0000 && s_r.misses + 18'h0_0001 == s_r.thresh)
    |=> s_r.thrFlag)
    else $error("threshold flag missed");

  // and raises the pulse when enabled
  thr_irq_a: assert property (@(posedge clock) disable iff (rst)
    (s_r.run && missEv && s_r.irqEn && s_r.thresh != 18'h0_0000 && s_r.misses + 18'h0_0001 == s_r.thresh)
    |=> monitorIrq)
    else $error("threshold irq missed");

  // zero threshold never sets the flag
  thr_zero_a: assert property (@(posedge clock) disable iff (rst)
    (s_r.thresh == 18'h0_0000 && !s_r.thrFlag && !wr)
    |=> !s_r.thrFlag)
    else $error("threshold flag with zero threshold");

  // checks on the interval counter
  // zero interval never sets the flag
  int_zero_a: assert property (@(posedge clock) disable iff (rst)
    (s_r.interval == 18'h0_0000 && !s_r.intFlag && !wr)
    |=> !s_r.intFlag)
    else $error("interval flag with zero interval");

  // end of countdown stops the run and sets the flag
  expire_a: assert property (@(posedge clock) disable iff (rst)
    (s_r.run && s_r.interval != 18'h0_0000 && refTick && s_r.tick <= 18'h0_0001 && !wr)
    |=> !s_r.run && s_r.intFlag)
    else $error("interval end missed");

  // end of countdown pulses when enabled
  expire_irq_a: assert property (@(posedge clock) disable iff (rst)
    (s_r.run && s_r.interval != 18'h0_0000 && refTick && s_r.tick <= 18'h0_0001 && s_r.irqEn)
    |=> monitorIrq)
    else $error("interval irq missed");

  // one step down per reference tick
  tick_step_a: assert property (@(posedge clock) disable iff (rst)
    (s_r.run && s_r.interval != 18'h0_0000 && refTick && s_r.tick > 18'h0_0001)
    |=> s_r.tick == $past(s_r.tick) - 18'h0_0001)
    else $error("interval step wrong");

  // no step between reference ticks
  tick_hold_a: assert property (@(posedge clock) disable iff (rst)
    (s_r.run && !refTick)
    |=> $stable(s_r.tick))
    else $error("interval moved without tick");

  // stopped monitor keeps the countdown loaded
  reload_a: assert property (@(posedge clock) disable iff (rst)
    !s_r.run
    |=> s_r.tick == $past(s_r.interval))
    else $error("interval not reloaded");

  // checks on the counters
  // stopped counters hold
  hold_stop_a: assert property (@(posedge clock) disable iff (rst)
    (!s_r.run && !wr)
    |=> $stable(s_r.hits) && $stable(s_r.misses))
    else $error("counter moved while stopped");

  // only software starts the monitor
  run_hold_a: assert property (@(posedge clock) disable iff (rst)
    (!s_r.run && !wr)
    |=> !s_r.run)
    else $error("monitor started by itself");

  // a hit while running adds one
  hit_count_a: assert property (@(posedge clock) disable iff (rst)
    (s_r.run && hitEv && !wr && s_r.hits != 19'h7_FFFF)
    |=> s_r.hits == $past(s_r.hits) + 19'h0_0001)
    else $error("hit not counted");

  // no hit, no change
  hit_idle_a: assert property (@(posedge clock) disable iff (rst)
    (!hitEv && !wr)
    |=> $stable(s_r.hits))
    else $error("hit count moved without a hit");

  // a miss while running adds one
  miss_count_a: assert property (@(posedge clock) disable iff (rst)
    (s_r.run && missEv && !wr && s_r.misses != 18'h3_FFFF)
    |=> s_r.misses == $past(s_r.misses) + 18'h0_0001)
    else $error("miss not counted");

  // no miss, no change
  miss_idle_a: assert property (@(posedge clock) disable iff (rst)
    (!missEv && !wr)
    |=> $stable(s_r.misses))
    else $error("miss count moved without a miss");

  // software write replaces the hit count
  hits_wr_a: assert property (@(posedge clock) disable iff (rst)
    (wr && busAddr == `CCM_OFS_HITS)
    |=> s_r.hits == $past(busWdata[18:0]))
    else $error("hit count write lost");

  // software write replaces the miss count
  miss_wr_a: assert property (@(posedge clock) disable iff (rst)
    (wr && busAddr == `CCM_OFS_MISSES)
    |=> s_r.misses == $past(busWdata[17:0]))
    else $error("miss count write lost");

  // checks on control two and its outputs
  // control two takes the written fields
  ctrl2_wr_a: assert property (@(posedge clock) disable iff (rst)
    (wr && busAddr == `CCM_OFS_CTRL2)
    |=> s_r.ctrl2 == $past(busWdata[11:0]))
    else $error("control two write lost");

  // zero length turns the cache off
  len_zero_a: assert property (@(posedge clock) disable iff (rst)
    (s_r.ctrl2.cacheLen == 9'h000)
    |=> !cacheEnable || $changed(s_r.ctrl2))
    else $error("cache on with zero length");

  // cache enable follows the length field
  len_on_a: assert property (@(posedge clock) disable iff (rst)
    cacheEnable
    == (s_r.ctrl2.cacheLen != 9'h000))
    else $error("cache enable wrong");

  // otp caching clips the region to 16 MB
  otp_len_a: assert property (@(posedge clock) disable iff (rst)
    s_r.ctrl2.otpCache
    |-> cacheableFlashLength <= `CCM_LEN_OTP_MAX)
    else $error("length over 16 MB with otp");

  // without otp caching the length passes unchanged
  len_pass_a: assert property (@(posedge clock) disable iff (rst)
    !s_r.ctrl2.otpCache
    |-> cacheableFlashLength == s_r.ctrl2.cacheLen)
    else $error("length not passed through");

  // array write enable mirrors its bit
  wen_a: assert property (@(posedge clock) disable iff (rst)
    arrayWriteEn
    == s_r.ctrl2.memWen)
    else $error("array write enable wrong");

  // checks on clock gating
  // gating needs its enable bit
  gate_a: assert property (@(posedge clock) disable iff (rst)
    clockGateEn
    |-> s_r.ctrl2.gateEn)
    else $error("gating without enable");

  // never gate while flushing
  gate_flush_a: assert property (@(posedge clock) disable iff (rst)
    flushBusy
    |-> !clockGateEn)
    else $error("gating during flush");

  // never gate a busy controller
  gate_busy_a: assert property (@(posedge clock) disable iff (rst)
    $past(cacheBusy)
    |-> !clockGateEn)
    else $error("gating while busy");

  // idle controller with the bit set is gated
  gate_on_a: assert property (@(posedge clock) disable iff (rst)
    (s_r.ctrl2.gateEn && !cacheBusy && s_r.flushCnt <= 16'h0001 && !wr)
    |=> clockGateEn)
    else $error("gating not applied");

  // checks on the flush timer
  // a flush write starts the timer
  flush_load_a: assert property (@(posedge clock) disable iff (rst)
    (wr && busAddr == `CCM_OFS_CTRL1 && busWdata[`CCM_BIT_FLUSH])
    |=> flushBusy)
    else $error("flush not started");

  // with the count fixed by the cache size
  flush_len_a: assert property (@(posedge clock) disable iff (rst)
    (wr && busAddr == `CCM_OFS_CTRL1 && busWdata[`CCM_BIT_FLUSH])
    |=> s_r.flushCnt == (LARGE_CACHE ? `CCM_FLUSH_16K : `CCM_FLUSH_8K))
    else $error("flush length wrong");

  // counting down one per bus clock
  flush_step_a: assert property (@(posedge clock) disable iff (rst)
    (s_r.flushCnt != 16'h0000 && !wr)
    |=> s_r.flushCnt == $past(s_r.flushCnt) - 16'h0001)
    else $error("flush step wrong");

  // checks on read data
  // read data stand one cycle only
  rd_idle_a: assert property (@(posedge clock) disable iff (rst)
    !busRd
    |=> busRdata == 32'h0000_0000)
    else $error("read data outside read cycle");

  // hit count read back
  rd_hits_a: assert property (@(posedge clock) disable iff (rst)
    (busRd && busAddr == `CCM_OFS_HITS)
    |=> busRdata == {13'h0000, $past(s_r.hits)})
    else $error("hit count read wrong");

  // run bit read back
  rd_ctrl_a: assert property (@(posedge clock) disable iff (rst)
    (busRd && busAddr == `CCM_OFS_MCTRL)
    |=> busRdata[`CCM_BIT_RUN] == $past(s_r.run))
    else $error("run bit read wrong");

  // main scenarios reached
  c_thr: cover property (@(posedge clock) disable iff (rst) $rose(s_r.thrFlag) && monitorIrq);
  c_int: cover property (@(posedge clock) disable iff (rst) $rose(s_r.intFlag));
  c_flush: cover property (@(posedge clock) disable iff (rst) $fell(flushBusy));
  c_gate: cover property (@(posedge clock) disable iff (rst) $rose(clockGateEn));
  c_clip: cover property (@(posedge clock) disable iff (rst)
    s_r.ctrl2.otpCache && s_r.ctrl2.cacheLen > `CCM_LEN_OTP_MAX);
endmodule
`default_nettype wire

// >>> ccm_event_source.sv
// behavioural cache controller that issues hit and miss events
`default_nettype none
module ccm_event_source (
  input  wire logic       clock,
  input  wire logic       rst,
  input  wire logic       load,
  input  wire logic [7:0] hitReq,
  input  wire logic [7:0] missReq,
  output logic            cacheHit,
  output logic            cacheMiss,
  output logic            cacheBusy
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] hitLeft;
  logic [7:0] missLeft;
  // one event of each kind per clock until the batch is spent
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      hitLeft  <= 8'h00;
      missLeft <= 8'h00;
    end else if (load) begin
      hitLeft  <= hitReq;
      missLeft <= missReq;
    end else begin
      hitLeft  <= hitLeft - 8'((hitLeft != 8'h00));
      missLeft <= missLeft - 8'((missLeft != 8'h00));
    end
  end
  // events stay as levels, so back-to-back hits look like one long strobe
  assign cacheHit  = hitLeft != 8'h00;
  assign cacheMiss = missLeft != 8'h00;
  assign cacheBusy = cacheHit | cacheMiss;
endmodule
`default_nettype wire

// >>> tb_cache_ctrl_miss_rate_monitor.sv
// register-level bench for the cache control and miss rate monitor
`default_nettype none
`include "ccm_map.svh"
module tb_cache_ctrl_miss_rate_monitor;
  import ccm_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock = 0, rst, busWr, busRd, load, monitorIrq, cacheEnable;
  logic clockGateEn, arrayWriteEn, flushBusy, cacheHit, cacheMiss, cacheBusy;
  logic [31:0] busAddr, busWdata, busRdata;
  logic [8:0]  cacheableFlashLength;
  logic [7:0]  hitReq, missReq;
  int n_mismatch = 0, compares = 0, nIrq = 0, mark, i, n;
  logic [31:0] ofs [6] = '{`CCM_OFS_CTRL2, `CCM_OFS_HITS, `CCM_OFS_MISSES,
                           `CCM_OFS_MCTRL, `CCM_OFS_INTERVAL, `CCM_OFS_THRESH};
  // 50 MHz
  always #10 clock = ~clock;
  always @(posedge clock) if (monitorIrq === 1'b1) nIrq++;
  ccm_monitor dut (.clock(clock), .rst(rst), .busAddr(busAddr), .busWdata(busWdata),
    .busWr(busWr), .busRd(busRd), .busRdata(busRdata), .cacheHit(cacheHit),
    .cacheMiss(cacheMiss), .cacheBusy(cacheBusy), .monitorIrq(monitorIrq),
    .cacheEnable(cacheEnable), .clockGateEn(clockGateEn), .arrayWriteEn(arrayWriteEn),
    .flushBusy(flushBusy), .cacheableFlashLength(cacheableFlashLength));
  ccm_event_source src (.clock(clock), .rst(rst), .load(load), .hitReq(hitReq),
    .missReq(missReq), .cacheHit(cacheHit), .cacheMiss(cacheMiss), .cacheBusy(cacheBusy));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      n_mismatch++;
    end
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    @(posedge clock);
    busWr <= 1'b1; busAddr <= a; busWdata <= d;
    @(posedge clock);
    busWr <= 1'b0;
  endtask
  // read data live only in the cycle after the strobe
  task automatic rd(input logic [31:0] a, input logic [31:0] exp);
    @(posedge clock);
    busRd <= 1'b1; busAddr <= a;
    @(posedge clock);
    busRd <= 1'b0;
    #1 chk(busRdata, exp);
  endtask
  task automatic issue(input logic [7:0] h, input logic [7:0] m);
    @(posedge clock);
    load <= 1'b1; hitReq <= h; missReq <= m;
    @(posedge clock);
    load <= 1'b0;
    repeat (260) @(posedge clock);
  endtask
  task automatic settle();
    repeat (2) @(posedge clock);
    #1;
  endtask
  task automatic finish_test();
    $display("compares=%0d mismatches=%0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // hang guard, far beyond the few thousand cycles the tests need
  initial begin
    repeat (20000) @(posedge clock);
    n_mismatch++;
    finish_test();
  end
  initial begin
    {busWr, busRd, load} = 3'b000; busAddr = 0; busWdata = 0; hitReq = 0; missReq = 0;
    rst = 1'b1;
    repeat (16) @(posedge clock);
    rst <= 1'b0;
    for (i = 0; i < 6; i++) rd(ofs[i], 32'h0000_0000);
    rd(32'h400C_3024, 32'h0000_0000);
    $display("test reset values done");
    wr(`CCM_OFS_CTRL2, 32'hFFFF_FFFF);
    rd(`CCM_OFS_CTRL2, 32'h0000_0FFF);
    settle();
    chk(32'(cacheableFlashLength), 32'h0000_0100);
    chk(32'(arrayWriteEn), 32'h0000_0001);
    chk(32'(clockGateEn), 32'h0000_0001);
    wr(`CCM_OFS_CTRL2, 32'h0000_01FF);
    settle();
    chk(32'(cacheableFlashLength), 32'h0000_01FF);
    chk(32'(cacheEnable), 32'h0000_0001);
    chk(32'(clockGateEn), 32'h0000_0000);
    chk(32'(arrayWriteEn), 32'h0000_0000);
    wr(`CCM_OFS_CTRL2, 32'h0000_0000);
    settle();
    chk(32'(cacheEnable), 32'h0000_0000);
    $display("test control two done");
    wr(`CCM_OFS_CTRL1, 32'h0000_0001);
    n = 0;
    // sample just after each edge, from the cycle the load lands
    for (i = 0; i < 768; i++) begin
      #1;
      if (flushBusy === 1'b1) n++;
      @(posedge clock);
    end
    chk(32'(n), 32'h0000_0200);
    $display("test flush done");
    wr(`CCM_OFS_HITS, 32'h0007_FFFE);
    rd(`CCM_OFS_HITS, 32'h0007_FFFE);
    issue(8'h03, 8'h03);
    rd(`CCM_OFS_HITS, 32'h0007_FFFE);
    wr(`CCM_OFS_MCTRL, 32'h0000_0001);
    issue(8'h03, 8'h02);
    wr(`CCM_OFS_MCTRL, 32'h0000_0000);
    rd(`CCM_OFS_HITS, 32'h0000_0001);
    rd(`CCM_OFS_MISSES, 32'h0000_0002);
    $display("test counters done");
    wr(`CCM_OFS_MISSES, 32'h0000_0000);
    wr(`CCM_OFS_THRESH, 32'h0000_0003);
    mark = nIrq;
    wr(`CCM_OFS_MCTRL, 32'h0000_0003);
    issue(8'h00, 8'h03);
    rd(`CCM_OFS_MCTRL, 32'h0000_000B);
    chk(32'(nIrq - mark), 32'h0000_0001);
    wr(`CCM_OFS_MCTRL, 32'h0000_0000);
    rd(`CCM_OFS_MCTRL, 32'h0000_0000);
    wr(`CCM_OFS_MISSES, 32'h0000_0000);
    mark = nIrq;
    wr(`CCM_OFS_MCTRL, 32'h0000_0001);
    issue(8'h00, 8'h03);
    rd(`CCM_OFS_MCTRL, 32'h0000_0009);
    chk(32'(nIrq - mark), 32'h0000_0000);
    $display("test threshold done");
    wr(`CCM_OFS_THRESH, 32'h0000_0000);
    wr(`CCM_OFS_MISSES, 32'h0003_FFFF);
    mark = nIrq;
    wr(`CCM_OFS_MCTRL, 32'h0000_0003);
    issue(8'h00, 8'h01);
    rd(`CCM_OFS_MCTRL, 32'h0000_0003);
    chk(32'(nIrq - mark), 32'h0000_0000);
    wr(`CCM_OFS_MCTRL, 32'h0000_0000);
    wr(`CCM_OFS_INTERVAL, 32'h0000_000A);
    mark = nIrq;
    wr(`CCM_OFS_MCTRL, 32'h0000_0003);
    repeat (20) @(posedge clock);
    rd(`CCM_OFS_MCTRL, 32'h0000_0003);
    repeat (30) @(posedge clock);
    rd(`CCM_OFS_MCTRL, 32'h0000_0006);
    chk(32'(nIrq - mark), 32'h0000_0001);
    $display("test interval done");
    finish_test();
  end
endmodule
`default_nettype wire
